// [general_purpose_timers.sv]
// Three 16-bit timers, B and C pairable to 32 bits, APB register slave
// Behaviour
// R1: Timer A runs as timer, synchronous counter or asynchronous counter.
// R2: Timer A flags on period match or gate falling edge when gated.
// R3: Control bit 15 starts the timer when 1, stops when 0.
// R4: Bit 13 set halts the timer during Idle; clear keeps it running.
// R5: Gated bit 6 ignored with external clock; else enables gating.
// R6: Bits 5-4 prescale input clock by 1, 8, 64 or 256.
// R7: Timer A bit 2 selects synchronised external clock; ignored if internal.
// R8: Bit 1 selects external pin rising edges, else internal clock.
// R9: Timer B bit 3 pairs B and C into one 32-bit timer.
// R10: When paired B holds the low word, C the high word.
// R11: When paired all timer C control bits are ignored.
// R12: Paired period match sets timer C flag, not timer B.
// R13: Paired period is C period upper word, B period lower word.
// R14: Paired count reads as C count upper and B count lower.
// R15: Timers B and C offer no asynchronous counting.
// R16: Paired timer flags when 32-bit count equals 32-bit period.
// R17: When paired timer B run bit starts and stops the 32-bit timer.
// R18: Timers B and C counts feed capture and compare as time bases.
// R19: Only the paired timer produces the converter trigger.
// R20: Timers keep working in Idle or Sleep subject to idle halt; the code stops all but asynchronous timer A in Sleep.
// R21: Software sets pairing, prescale, clock, period, then run bit.
// R22: At period match count returns to zero next tick; flag set.
// R23: Gated accumulation counts internal ticks only while gate high.
// R24: Unimplemented control bits read zero and ignore writes.
`timescale 1ns/10ps

module general_purpose_timers (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  input  wire logic        timer_a_ext_clock_pin,
  input  wire logic        timer_b_ext_clock_pin,
  input  wire logic        timer_c_ext_clock_pin,
  input  wire logic        timer_a_gate_pin,
  input  wire logic        timer_b_gate_pin,
  input  wire logic        timer_c_gate_pin,
  output logic [2:0]       timer_irq_flag,
  output logic [15:0]      timer_b_count,
  output logic [15:0]      timer_c_count,
  output logic             converter_trigger
);

  logic [2:0][15:0] ctrl_r;
  logic [2:0][15:0] count_r;
  logic [2:0][15:0] period_r;
  logic [2:0]       flags_r;
  logic [2:0][7:0]  psc_r;
  logic [2:0]       clk_s1_r;
  logic [2:0]       clk_s2_r;
  logic [2:0]       clk_s3_r;
  logic [2:0]       gate_s1_r;
  logic [2:0]       gate_s2_r;
  logic [2:0]       gate_s3_r;
  logic [31:0]      prdata_r;
  logic             trig_r;

  logic [2:0]       pins_clk;
  logic [2:0]       pins_gate;
  logic [2:0]       tick_own;
  logic [2:0]       tick;
  logic [2:0]       run_eff;
  logic [2:0]       gate_fall_ev;
  logic [2:0]       flag_set;
  logic             pair;
  logic             match32;
  logic             wr_en;
  logic             rd_setup;
  logic             mapped;

  assign pins_clk  = {timer_c_ext_clock_pin, timer_b_ext_clock_pin,
                      timer_a_ext_clock_pin};
  assign pins_gate = {timer_c_gate_pin, timer_b_gate_pin, timer_a_gate_pin};

  assign pair = ctrl_r[1][timers_pkg::BIT_PAIR]; // [R9]

  // Pin synchronisers, third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1_r  <= 3'h0;
      clk_s2_r  <= 3'h0;
      clk_s3_r  <= 3'h0;
      gate_s1_r <= 3'h0;
      gate_s2_r <= 3'h0;
      gate_s3_r <= 3'h0;
    end
    else
    begin
      clk_s1_r  <= pins_clk;
      clk_s2_r  <= clk_s1_r;
      clk_s3_r  <= clk_s2_r;
      gate_s1_r <= pins_gate;
      gate_s2_r <= gate_s1_r;
      gate_s3_r <= gate_s2_r;
    end
  end

  function automatic logic [7:0] psc_limit(input logic [1:0] code);
    logic [7:0] lim;
    lim = timers_pkg::PSC_LIM_1;
    case (code)
      timers_pkg::PSC_DIV1:   lim = timers_pkg::PSC_LIM_1;
      timers_pkg::PSC_DIV8:   lim = timers_pkg::PSC_LIM_8;
      timers_pkg::PSC_DIV64:  lim = timers_pkg::PSC_LIM_64;
      timers_pkg::PSC_DIV256: lim = timers_pkg::PSC_LIM_256;
      default:                lim = timers_pkg::PSC_LIM_1;
    endcase
    return lim;
  endfunction : psc_limit

  // Per-timer clock source, gating, prescaler and run qualification
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_tmr
      logic       ext_sel;
      logic       gated;
      logic       async_mode;
      logic       src_ev;
      logic [7:0] lim;

      assign ext_sel = ctrl_r[gi][timers_pkg::BIT_CLK_SRC]; // [R8]
      assign gated   = ctrl_r[gi][timers_pkg::BIT_GATED] & ~ext_sel; // [R5]
      // Only timer A may count asynchronously
      if (gi == 0)
      begin : g_async
        assign async_mode = ext_sel &
                            ~ctrl_r[gi][timers_pkg::BIT_SYNC]; // [R1] [R7]
      end
      else
      begin : g_sync
        assign async_mode = 1'b0; // [R15]
      end

      // Ungated internal clock counts every cycle; gate high only
      assign src_ev = ext_sel ? (clk_s2_r[gi] & ~clk_s3_r[gi])
                              : (~gated | gate_s2_r[gi]); // [R8] [R23]
      assign lim = psc_limit(ctrl_r[gi][timers_pkg::BIT_PSC_HI:
                                        timers_pkg::BIT_PSC_LO]); // [R6]

      // Sleep stops all but the asynchronous counter
      assign run_eff[gi] = ctrl_r[gi][timers_pkg::BIT_RUN] & // [R3]
                           ~(cpu_idle &
                             ctrl_r[gi][timers_pkg::BIT_IDLE]) & // [R4]
                           ~(cpu_sleep & ~async_mode); // [R20]

      assign tick_own[gi] = run_eff[gi] & src_ev & (psc_r[gi] == lim);

      assign gate_fall_ev[gi] = run_eff[gi] & gated &
                                ~gate_s2_r[gi] & gate_s3_r[gi]; // [R2]

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          psc_r[gi] <= 8'h00;
        else if (!run_eff[gi])
          psc_r[gi] <= 8'h00;
        else if (src_ev)
        begin
          if (psc_r[gi] >= lim)
            psc_r[gi] <= 8'h00;
          else
            psc_r[gi] <= psc_r[gi] + 8'h01; // [R6]
        end
      end
    end
  endgenerate

  // Paired timer C follows timer B clocking entirely
  assign tick[0] = tick_own[0];
  assign tick[1] = tick_own[1];
  assign tick[2] = pair ? tick_own[1] : tick_own[2]; // [R11] [R17]

  assign match32 = pair &&
                   ({count_r[2], count_r[1]} ==
                    {period_r[2], period_r[1]}); // [R13] [R16]

  // APB decode
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped   = (paddr[1:0] == 2'b00) &&
                    (paddr <= timers_pkg::OFS_FLAGS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign prdata   = prdata_r;

  // Control registers with writable masks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r[0] <= timers_pkg::RST_CONTROL;
      ctrl_r[1] <= timers_pkg::RST_CONTROL;
      ctrl_r[2] <= timers_pkg::RST_CONTROL;
    end
    else if (wr_en)
    begin
      if (paddr == timers_pkg::OFS_A_CONTROL)
        ctrl_r[0] <= pwdata[15:0] & timers_pkg::MASK_A_CONTROL; // [R24]
      if (paddr == timers_pkg::OFS_B_CONTROL)
        ctrl_r[1] <= pwdata[15:0] & timers_pkg::MASK_B_CONTROL; // [R24]
      if (paddr == timers_pkg::OFS_C_CONTROL)
        ctrl_r[2] <= pwdata[15:0] & timers_pkg::MASK_C_CONTROL; // [R24]
    end
  end

  // Period registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      period_r[0] <= timers_pkg::RST_PERIOD;
      period_r[1] <= timers_pkg::RST_PERIOD;
      period_r[2] <= timers_pkg::RST_PERIOD;
    end
    else if (wr_en)
    begin
      if (paddr == timers_pkg::OFS_A_PERIOD)
        period_r[0] <= pwdata[15:0];
      if (paddr == timers_pkg::OFS_B_PERIOD)
        period_r[1] <= pwdata[15:0];
      if (paddr == timers_pkg::OFS_C_PERIOD)
        period_r[2] <= pwdata[15:0];
    end
  end

  // Timer A count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r[0] <= timers_pkg::RST_COUNT;
    else if (wr_en && paddr == timers_pkg::OFS_A_COUNT)
      count_r[0] <= pwdata[15:0];
    else if (tick[0])
    begin
      if (count_r[0] == period_r[0])
        count_r[0] <= 16'h0000; // [R22]
      else
        count_r[0] <= count_r[0] + 16'h0001; // [R1]
    end
  end

  // Timer B count, low word when paired
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r[1] <= timers_pkg::RST_COUNT;
    else if (wr_en && paddr == timers_pkg::OFS_B_COUNT)
      count_r[1] <= pwdata[15:0];
    else if (tick[1])
    begin
      if (pair ? match32 : (count_r[1] == period_r[1]))
        count_r[1] <= 16'h0000; // [R22] [R10]
      else
        count_r[1] <= count_r[1] + 16'h0001;
    end
  end

  // Timer C count, high word when paired
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r[2] <= timers_pkg::RST_COUNT;
    else if (wr_en && paddr == timers_pkg::OFS_C_COUNT)
      count_r[2] <= pwdata[15:0];
    else if (tick[2])
    begin
      if (pair)
      begin
        if (match32)
          count_r[2] <= 16'h0000; // [R16] [R22]
        else if (count_r[1] == 16'hFFFF)
          count_r[2] <= count_r[2] + 16'h0001; // [R10]
      end
      else if (count_r[2] == period_r[2])
        count_r[2] <= 16'h0000; // [R22]
      else
        count_r[2] <= count_r[2] + 16'h0001;
    end
  end

  // Flag events
  assign flag_set[0] = (tick[0] && count_r[0] == period_r[0]) |
                       gate_fall_ev[0]; // [R2]
  assign flag_set[1] = ~pair &
                       ((tick[1] && count_r[1] == period_r[1]) |
                        gate_fall_ev[1]); // [R12]
  assign flag_set[2] = pair ? ((tick[1] & match32) | gate_fall_ev[1])
                            : ((tick[2] && count_r[2] == period_r[2]) |
                               gate_fall_ev[2]); // [R12] [R16]

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= 3'h0;
    else if (wr_en && paddr == timers_pkg::OFS_FLAGS)
      flags_r <= (flags_r & ~pwdata[2:0]) | flag_set;
    else
      flags_r <= flags_r | flag_set; // [R22]
  end

  // Converter trigger pulse from the paired timer only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_r <= 1'b0;
    else
      trig_r <= pair & tick[1] & match32; // [R19]
  end

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else if (rd_setup)
    begin
      case (paddr)
        timers_pkg::OFS_A_CONTROL: prdata_r <= {16'h0000, ctrl_r[0]};
        timers_pkg::OFS_A_COUNT:   prdata_r <= {16'h0000, count_r[0]};
        timers_pkg::OFS_A_PERIOD:  prdata_r <= {16'h0000, period_r[0]};
        timers_pkg::OFS_B_CONTROL: prdata_r <= {16'h0000, ctrl_r[1]};
        timers_pkg::OFS_B_COUNT:   prdata_r <= {16'h0000, count_r[1]};
        timers_pkg::OFS_B_PERIOD:  prdata_r <= {16'h0000, period_r[1]};
        timers_pkg::OFS_C_CONTROL: prdata_r <= {16'h0000, ctrl_r[2]};
        timers_pkg::OFS_C_COUNT:   prdata_r <= {16'h0000, count_r[2]}; // [R14]
        timers_pkg::OFS_C_PERIOD:  prdata_r <= {16'h0000, period_r[2]};
        timers_pkg::OFS_FLAGS:     prdata_r <= {29'h00000000, flags_r};
        default:                   prdata_r <= 32'h00000000;
      endcase
    end
  end

  assign timer_irq_flag    = flags_r;
  assign timer_b_count     = count_r[1]; // [R18]
  assign timer_c_count     = count_r[2]; // [R18]
  assign converter_trigger = trig_r;

endmodule : general_purpose_timers

// [timers_pkg.sv]
// Package with register map, field positions and constants for the timers
package timers_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_TIMERS = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_A_CONTROL = 8'h00;
  localparam logic [7:0] OFS_A_COUNT   = 8'h04;
  localparam logic [7:0] OFS_A_PERIOD  = 8'h08;
  localparam logic [7:0] OFS_B_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_B_COUNT   = 8'h10;
  localparam logic [7:0] OFS_B_PERIOD  = 8'h14;
  localparam logic [7:0] OFS_C_CONTROL = 8'h18;
  localparam logic [7:0] OFS_C_COUNT   = 8'h1C;
  localparam logic [7:0] OFS_C_PERIOD  = 8'h20;
  localparam logic [7:0] OFS_FLAGS     = 8'h24;
  localparam logic [7:0] OFS_STRIDE    = 8'h0C;

  // Control field positions
  localparam int unsigned BIT_RUN      = 15;
  localparam int unsigned BIT_IDLE     = 13;
  localparam int unsigned BIT_GATED    = 6;
  localparam int unsigned BIT_PSC_HI   = 5;
  localparam int unsigned BIT_PSC_LO   = 4;
  localparam int unsigned BIT_PAIR     = 3;
  localparam int unsigned BIT_SYNC     = 2;
  localparam int unsigned BIT_CLK_SRC  = 1;

  // Writable bit masks per control register
  localparam logic [15:0] MASK_A_CONTROL = 16'hA076;
  localparam logic [15:0] MASK_B_CONTROL = 16'hA07A;
  localparam logic [15:0] MASK_C_CONTROL = 16'hA072;

  // Reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_PERIOD  = 16'hFFFF;

  // Prescaler terminal counts (divide minus one)
  localparam logic [7:0] PSC_LIM_1   = 8'h00;
  localparam logic [7:0] PSC_LIM_8   = 8'h07;
  localparam logic [7:0] PSC_LIM_64  = 8'h3F;
  localparam logic [7:0] PSC_LIM_256 = 8'hFF;

  typedef enum logic [1:0] {
    PSC_DIV1   = 2'b00,
    PSC_DIV8   = 2'b01,
    PSC_DIV64  = 2'b10,
    PSC_DIV256 = 2'b11
  } prescale_t;

endpackage : timers_pkg

// [timer_pins_model.sv]
// Far-side model of the timer clock and gate pins
`timescale 1ns/10ps

module timer_pins_model (
  input  wire logic       pclk,
  input  wire logic [2:0] pulse_req,
  input  wire logic [2:0] gate_req,
  output logic      [2:0] ext_clock,
  output logic      [2:0] gate
);
  // Clock pins toggle while asked, rest low between bursts
  always_ff @(posedge pclk)
  begin
    ext_clock <= pulse_req & ~ext_clock;
    gate      <= gate_req;
  end
endmodule : timer_pins_model

// [general_purpose_timers_props.sv]
// Port checker for the general purpose timers, with its bind
`timescale 1ns/10ps

module general_purpose_timers_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        cpu_idle,
  input wire logic        cpu_sleep,
  input wire logic        timer_a_ext_clock_pin,
  input wire logic        timer_b_ext_clock_pin,
  input wire logic        timer_c_ext_clock_pin,
  input wire logic        timer_a_gate_pin,
  input wire logic        timer_b_gate_pin,
  input wire logic        timer_c_gate_pin,
  input wire logic [2:0]  timer_irq_flag,
  input wire logic [15:0] timer_b_count,
  input wire logic [15:0] timer_c_count,
  input wire logic        converter_trigger
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic acc_wr;
  logic flags_wr;
  assign acc_wr   = psel && penable && pwrite;
  assign flags_wr = acc_wr && paddr == timers_pkg::OFS_FLAGS;

  sequence trig_pulse;
    converter_trigger ##1 !converter_trigger;
  endsequence

  a_ready_high:
    assert property (psel && penable |-> pready)
    else $error("Ready low in access phase");
  a_slverr_bad:
    assert property (psel && penable &&
      (paddr > 8'h24 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("No error on unmapped address");
  a_slverr_good:
    assert property (psel && penable && paddr <= 8'h24 &&
      paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("Error on mapped address");
  a_trig_pulse:
    assert property ($rose(converter_trigger) |-> trig_pulse)
    else $error("Trigger longer than one cycle");
  a_trig_flag:
    assert property (converter_trigger |-> timer_irq_flag[2])
    else $error("Trigger without high word flag");
  a_flag_sticky:
    assert property (|($past(timer_irq_flag) & ~timer_irq_flag)
      |-> $past(flags_wr))
    else $error("Flag cleared without write");
  a_b_count_step:
    assert property ($changed(timer_b_count) && !$past(acc_wr) |->
      timer_b_count == $past(timer_b_count) + 16'h0001 ||
      timer_b_count == 16'h0000)
    else $error("Low count jumped");
  a_c_count_step:
    assert property ($changed(timer_c_count) && !$past(acc_wr) |->
      timer_c_count == $past(timer_c_count) + 16'h0001 ||
      timer_c_count == 16'h0000)
    else $error("High count jumped");
  a_prdata_hold:
    assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("Read data changed outside setup");
endmodule : general_purpose_timers_props

bind general_purpose_timers general_purpose_timers_props props_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .prdata, .pslverr, .cpu_idle, .cpu_sleep, .timer_a_ext_clock_pin,
  .timer_b_ext_clock_pin, .timer_c_ext_clock_pin, .timer_a_gate_pin,
  .timer_b_gate_pin, .timer_c_gate_pin, .timer_irq_flag, .timer_b_count,
  .timer_c_count, .converter_trigger
);

// [general_purpose_timers_tb_top.sv]
// Self-checking bench for the general purpose timers
`timescale 1ns/10ps

module general_purpose_timers_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        cpu_idle = 1'b0;
  logic        cpu_sleep = 1'b0;
  logic [2:0]  pulse_req = 3'h0;
  logic [2:0]  gate_req = 3'h0;
  logic [2:0]  ext_clk;
  logic [2:0]  gate;
  logic [2:0]  flag;
  logic [15:0] cnt_b;
  logic [15:0] cnt_c;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        trig;
  logic        t;
  int          n;
  int          mismatches = 0;
  int          checked = 0;

  always #25 pclk = ~pclk;

  timer_pins_model pins_u (.pclk, .pulse_req, .gate_req,
    .ext_clock(ext_clk), .gate);

  general_purpose_timers dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .cpu_idle,
    .cpu_sleep, .timer_a_ext_clock_pin(ext_clk[0]),
    .timer_b_ext_clock_pin(ext_clk[1]), .timer_c_ext_clock_pin(ext_clk[2]),
    .timer_a_gate_pin(gate[0]), .timer_b_gate_pin(gate[1]),
    .timer_c_gate_pin(gate[2]), .timer_irq_flag(flag),
    .timer_b_count(cnt_b), .timer_c_count(cnt_c),
    .converter_trigger(trig));

  task automatic check(input string w, input logic [31:0] s,
                       input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic cycles(input int c);
    t = 1'b0;
    repeat (c)
    begin
      @(posedge pclk);
      t |= trig;
    end
  endtask : cycles

  task automatic wait_chg;
    logic [15:0] v;
    v = cnt_b;
    n = 0;
    while (cnt_b === v && n < 600)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_chg

  task automatic t_regs;
    logic [15:0] m [3] = '{16'h2076, 16'h207A, 16'h2072};
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 8'(4 * i), 16'h0);
      check("reset value", rd, (i % 3 == 2 && i < 9) ? 32'hFFFF : 32'h0);
    end
    apb(1'b0, 8'h28, 16'h0);
    check("unmapped", {serr, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'(12 * i), 16'h7FFF);
      apb(1'b0, 8'(12 * i), 16'h0);
      check("control bits", rd, {16'h0, m[i]});
      wr(8'(12 * i), 16'h0000);
    end
  endtask : t_regs

  task automatic t_gate_idle;
    wr(timers_pkg::OFS_B_COUNT, 16'h0000);
    wr(timers_pkg::OFS_A_CONTROL, 16'h8040);
    wr(timers_pkg::OFS_B_CONTROL, 16'h8040);
    cycles(20);
    check("gate low", cnt_b, 32'h0);
    gate_req <= 3'b011;
    cycles(20);
    gate_req <= 3'b000;
    cycles(6);
    check("gate high", cnt_b, 32'h14);
    check("gate fall flag", flag, 3'b011);
    wr(timers_pkg::OFS_FLAGS, 16'h0007);
    wr(timers_pkg::OFS_B_COUNT, 16'h0000);
    cpu_idle <= 1'b1;
    wr(timers_pkg::OFS_B_CONTROL, 16'hA000);
    cycles(10);
    check("idle halt", cnt_b, 32'h0);
    wr(timers_pkg::OFS_B_CONTROL, 16'h8000);
    cycles(10);
    check("idle run", cnt_b, 32'hA);
    cpu_idle <= 1'b0;
  endtask : t_gate_idle

  task automatic t_count;
    int div [4] = '{1, 8, 64, 256};
    wr(timers_pkg::OFS_A_CONTROL, 16'h0000);
    wr(timers_pkg::OFS_A_COUNT, 16'h0000);
    wr(timers_pkg::OFS_A_PERIOD, 16'h0002);
    wr(timers_pkg::OFS_A_CONTROL, 16'h8000);
    cycles(4);
    check("period flag", flag, 3'b001);
    check("no trigger", t, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      wr(timers_pkg::OFS_B_CONTROL, 16'h8000 | 16'(c << 4));
      wait_chg();
      wait_chg();
      check("prescale", n, div[c]);
    end
    wr(timers_pkg::OFS_B_CONTROL, 16'h0000);
    m_hold();
  endtask : t_count

  task automatic m_hold;
    logic [15:0] v;
    v = cnt_b;
    cycles(10);
    check("stopped", cnt_b, {16'h0, v});
  endtask : m_hold

  task automatic t_pair_ext;
    wr(timers_pkg::OFS_B_PERIOD, 16'h0001);
    wr(timers_pkg::OFS_C_PERIOD, 16'h0001);
    wr(timers_pkg::OFS_B_COUNT, 16'hFFFE);
    wr(timers_pkg::OFS_C_COUNT, 16'h0000);
    wr(timers_pkg::OFS_C_CONTROL, 16'h0030);
    wr(timers_pkg::OFS_B_CONTROL, 16'h8008);
    for (int k = 0; k < 20 && {cnt_c, cnt_b} !== 32'h00010001; k++)
      @(posedge pclk);
    cycles(1);
    check("pair wrap", {cnt_c, cnt_b}, 32'h0);
    check("pair flag", flag, 3'b101);
    check("pair trigger", t, 1'b1);
    cycles(2);
    check("trigger width", t, 1'b0);
    wr(timers_pkg::OFS_B_CONTROL, 16'h0000);
    wr(timers_pkg::OFS_B_PERIOD, 16'hFFFF);
    wr(timers_pkg::OFS_B_COUNT, 16'h0000);
    wr(timers_pkg::OFS_B_CONTROL, 16'h8002);
    pulse_req <= 3'b010;
    cycles(10);
    pulse_req <= 3'b000;
    cycles(6);
    check("pin edges", cnt_b, 32'h5);
  endtask : t_pair_ext

  task automatic t_sleep;
    cpu_sleep <= 1'b1;
    wr(timers_pkg::OFS_A_PERIOD, 16'hFFFF);
    for (int s = 0; s < 2; s++)
    begin
      wr(timers_pkg::OFS_A_COUNT, 16'h0000);
      wr(timers_pkg::OFS_A_CONTROL, (s != 0) ? 16'h8006 : 16'h8002);
      pulse_req <= 3'b001;
      cycles(10);
      pulse_req <= 3'b000;
      cycles(6);
      apb(1'b0, timers_pkg::OFS_A_COUNT, 16'h0);
      check("sleep count", rd, (s != 0) ? 32'h0 : 32'h5);
    end
    cpu_sleep <= 1'b0;
  endtask : t_sleep

  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_gate_idle();
    t_count();
    t_pair_ext();
    t_sleep();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    final_report();
  end
endmodule : general_purpose_timers_tb_top
